//--- status_irq_pkg.sv
// Package for the status and interrupt reporting block of a dual-redundant bus terminal.
// Holds the register map, field positions, reset values and the structs that carry event groups.
// Assumes a 32-bit APB master whose byte address is four times each register index.
package status_irq_pkg;

    // Register indices; the byte address on the bus is four times the index.
    localparam logic [5:0] IDX_SELF_TEST = 6'h1c;
    localparam logic [5:0] IDX_ENABLE    = 6'h1d;
    localparam logic [5:0] IDX_STATUS    = 6'h1e;
    localparam logic [5:0] IDX_QPTR      = 6'h1f;
    localparam logic [5:0] IDX_MSG_STAT  = 6'h20;
    localparam logic [5:0] IDX_MODE      = 6'h21;

    localparam logic [11:0] ADDR_SELF_TEST = {4'h0, IDX_SELF_TEST, 2'h0};
    localparam logic [11:0] ADDR_ENABLE    = {4'h0, IDX_ENABLE, 2'h0};
    localparam logic [11:0] ADDR_STATUS    = {4'h0, IDX_STATUS, 2'h0};
    localparam logic [11:0] ADDR_QPTR      = {4'h0, IDX_QPTR, 2'h0};
    localparam logic [11:0] ADDR_MSG_STAT  = {4'h0, IDX_MSG_STAT, 2'h0};
    localparam logic [11:0] ADDR_MODE      = {4'h0, IDX_MODE, 2'h0};

    // Reset values.
    localparam logic [15:0] RST_ENABLE   = 16'h0000;
    localparam logic [15:0] RST_STATUS   = 16'h0000;
    localparam logic [15:0] RST_QPTR     = 16'h0000;
    localparam logic [15:0] RST_MSG_STAT = 16'h0000;
    localparam logic [2:0]  RST_MODE     = 3'h0;

    // Writable bits of the enable register; bits 15 and 0 are unused and read zero.
    localparam logic [15:0] ENABLE_MASK = 16'h7ffe;

    // Event bit positions in the second status register.
    localparam int BIT_PENDING  = 15;
    localparam int BIT_PARITY   = 14;
    localparam int BIT_ILLEGAL  = 13;
    localparam int BIT_QWRAP    = 12;
    localparam int BIT_STACK    = 11;
    localparam int BIT_OPCODE   = 10;
    localparam int BIT_TSTACK   = 9;
    localparam int BIT_TRING    = 8;
    localparam int BIT_MSTACK   = 7;
    localparam int BIT_MDATA    = 6;
    localparam int BIT_CODE_HI  = 5;
    localparam int BIT_CODE_LO  = 2;
    localparam int BIT_SELFTEST = 1;
    localparam int BIT_SUMMARY  = 0;

    // Mode register bits.
    localparam int MODE_EBC = 0;
    localparam int MODE_RT  = 1;
    localparam int MODE_MT  = 2;

    // Queue pointer split: base in 15..6, next location in 5..0.
    localparam int QPTR_LOW_MSB = 5;
    localparam logic [5:0] QPTR_LOW_LAST = 6'h3f;

    // Retry field encodings.
    localparam logic [1:0] RETRY_NONE = 2'h0;
    localparam logic [1:0] RETRY_ONE  = 2'h1;
    localparam logic [1:0] RETRY_TWO  = 2'h2;

    typedef enum logic {MSG_IDLE, MSG_RUN} msg_state_e;

    typedef struct packed {
        logic       instruction_parity_fault;
        logic       illegal_command_event;
        logic       message_stored;
        logic       call_stack_fault;
        logic       bad_opcode_fetch;
        logic       terminal_stack_half;
        logic       terminal_ring_half;
        logic       monitor_stack_half;
        logic       monitor_data_half;
        logic       request_strobe;
        logic [3:0] controller_request_code;
        logic       self_test_done;
        logic       first_status_summary;
    } event_in_s;

    typedef struct packed {
        logic proto_complete;
        logic proto_running;
        logic proto_passed;
        logic proto_abort;
        logic ram_complete;
        logic ram_running;
        logic ram_passed;
    } self_test_s;

    typedef struct packed {
        logic        message_begin;
        logic        message_end;
        logic        bus_select_flag;
        logic        format_error;
        logic        response_timeout;
        logic        handshake_fail;
        logic        word_invalid;
        logic [15:0] tx_last_word;
        logic [15:0] echo_last_word;
        logic [10:0] rt_status;
        logic [10:0] expected_status;
        logic [5:0]  status_mask;
        logic [5:0]  mask_hits;
        logic [1:0]  retries;
    } msg_in_s;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } bsw_write_s;

endpackage : status_irq_pkg

//--- status_interrupt_reporting.sv
// Status and interrupt reporting: self-test flags, event enable/status pair, queue pointer
// and the controller block status word, all reached over a 32-bit APB slave.
// Assumes event inputs are one-cycle pulses from logic on pclk, and that shared RAM
// accepts the block status word whenever the write strobe is high.
//
// Notes on behaviour
// R1 - Event bits set regardless of enable; interrupt only where enable bit is one.
// R2 - Bit 14 marks a parity error in a fetched controller instruction.
// R3 - Bit 13: illegal command in terminal mode, stored message in monitor mode.
// R4 - Bit 12 marks queue rollover, general queue or status queue by mode.
// R5 - Bit 11 marks controller call stack overflow or underflow in enhanced mode.
// R6 - Bit 10 marks an illegal op code fetched by the controller.
// R7 - Bits 9 to 6 mark the four stacks and buffers reaching half full.
// R8 - Request instruction loads bits 5 to 2 with its parameter's low nibble.
// R9 - Bit 1 marks self-test completion; its enable gates the interrupt.
// R10 - Bit 15 reads one while any enabled event is pending.
// R11 - Bit 0 reads one while any bit of the first status register is set.
// R12 - Queue pointer holds base in bits 15..6, next location in 5..0.
// R13 - Self-test register shows protocol test flags in bits 15 to 11.
// R14 - RAM test flags sit in bits 7..5; bits 10..8 and 4..0 read zero.
// R15 - After each controller message a block status word goes to shared RAM.
// R16 - Block word bit 14 set at start, cleared at end; bit 15 set at end.
// R17 - Block word bit 13 is one for bus B, zero for bus A.
// R18 - Bit 12 flags errors; alone it means a handshake failure.
// R19 - Bit 11 flags unexpected status bits 10..0, ignoring the mask bits.
// R20 - Echo word invalid or last word mismatch sets block word bit 8.
// R21 - Bit 7 flags a status bit set that the control word masks.
// R22 - Bits 6..5 give retries: none, one, or two encoded as 10.
// R23 - Interrupt output stays high while any enabled event is pending.
`timescale 1ns/10ps
`default_nettype none

module status_interrupt_reporting (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        ce,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [11:0]                 paddr,
    input  wire logic [31:0]                 pwdata,
    output var  logic [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire status_irq_pkg::event_in_s   events,
    input  wire status_irq_pkg::self_test_s  self_test,
    input  wire status_irq_pkg::msg_in_s     msg,
    input  wire logic                        queue_advance,
    output var  logic [15:0]                 queue_pointer,
    output var  status_irq_pkg::bsw_write_s  bsw_write,
    output var  logic                        interrupt_request
);

    // Address match helper, used for every register decode.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] target);
        return a == target;
    endfunction : hit

    logic [15:0] event_enable_two;
    logic [15:0] event_status_two;
    logic [15:0] self_test_status;
    logic [15:0] controller_message_status;
    logic [2:0]  mode;
    logic        echo_check_fail;
    status_irq_pkg::msg_state_e msg_state;

    // Bus decode. The slave always answers in the first access cycle unless ce is low.
    wire logic sel_self_test = hit(paddr, status_irq_pkg::ADDR_SELF_TEST);
    wire logic sel_enable    = hit(paddr, status_irq_pkg::ADDR_ENABLE);
    wire logic sel_status    = hit(paddr, status_irq_pkg::ADDR_STATUS);
    wire logic sel_qptr      = hit(paddr, status_irq_pkg::ADDR_QPTR);
    wire logic sel_msg       = hit(paddr, status_irq_pkg::ADDR_MSG_STAT);
    wire logic sel_mode      = hit(paddr, status_irq_pkg::ADDR_MODE);
    wire logic mapped        = sel_self_test | sel_enable | sel_status | sel_qptr | sel_msg | sel_mode;
    wire logic read_only     = sel_self_test | sel_status;
    wire logic setup_phase   = ce & psel & ~penable;
    wire logic access_done   = ce & psel & penable;
    wire logic bad_access    = ~mapped | (pwrite & read_only);
    wire logic wr            = access_done & pwrite & ~bad_access;
    wire logic rd_status     = access_done & ~pwrite & sel_status;

    assign pready  = ce;
    assign pslverr = psel & penable & bad_access;

    // Mode qualifiers steer which events feed the shared bits.
    wire logic ebc_mode = mode[status_irq_pkg::MODE_EBC];
    wire logic rt_mode  = mode[status_irq_pkg::MODE_RT];
    wire logic mt_mode  = mode[status_irq_pkg::MODE_MT];

    // Queue pointer advance; the low field wraps inside the 64-word queue.
    wire logic qptr_wrap = queue_advance & (queue_pointer[status_irq_pkg::QPTR_LOW_MSB:0] ==
                                            status_irq_pkg::QPTR_LOW_LAST);
    wire logic queue_wrap_event = qptr_wrap & (ebc_mode | rt_mode | mt_mode);  // [R4]
    wire logic [5:0] next_qptr_low = queue_pointer[5:0] + 6'h01;  // [R12]

    // Event set vector for the sticky bits 14..6 and 1.
    logic [15:0] event_set;
    assign event_set[status_irq_pkg::BIT_PENDING] = 1'b0;
    assign event_set[status_irq_pkg::BIT_PARITY]  = events.instruction_parity_fault;  // [R2]
    assign event_set[status_irq_pkg::BIT_ILLEGAL] = (rt_mode & events.illegal_command_event) |
                                                    (mt_mode & events.message_stored);  // [R3]
    assign event_set[status_irq_pkg::BIT_QWRAP]   = queue_wrap_event;  // [R4]
    assign event_set[status_irq_pkg::BIT_STACK]   = ebc_mode & events.call_stack_fault;  // [R5]
    assign event_set[status_irq_pkg::BIT_OPCODE]  = events.bad_opcode_fetch;  // [R6]
    assign event_set[status_irq_pkg::BIT_TSTACK]  = events.terminal_stack_half;  // [R7]
    assign event_set[status_irq_pkg::BIT_TRING]   = events.terminal_ring_half;  // [R7]
    assign event_set[status_irq_pkg::BIT_MSTACK]  = events.monitor_stack_half;  // [R7]
    assign event_set[status_irq_pkg::BIT_MDATA]   = events.monitor_data_half;  // [R7]
    assign event_set[5:2] = 4'h0;
    assign event_set[status_irq_pkg::BIT_SELFTEST] = events.self_test_done;  // [R9]
    assign event_set[status_irq_pkg::BIT_SUMMARY]  = 1'b0;

    // Reading the status register clears only the bits that the read returned, so an
    // event landing between setup and access is kept: the set always wins.
    wire logic [15:0] read_clear = rd_status ? prdata[15:0] : 16'h0000;
    wire logic [15:0] sticky     = (event_status_two & ~read_clear) | event_set;  // [R1]
    wire logic [3:0]  next_code  = events.request_strobe ? events.controller_request_code :
                                   (event_status_two[5:2] & ~read_clear[5:2]);  // [R8]

    // Pending summary over the enabled event bits only.
    wire logic pending = |(event_status_two[14:1] & event_enable_two[14:1]);  // [R10] [R23]
    wire logic [15:0] status_view = {pending, event_status_two[14:1], events.first_status_summary};  // [R11]

    // Read multiplexer; unmapped reads return zero with an error answer.
    logic [15:0] read_word;
    assign read_word = sel_self_test ? self_test_status :
                       sel_enable    ? event_enable_two :
                       sel_status    ? status_view :
                       sel_qptr      ? queue_pointer :
                       sel_msg       ? controller_message_status :
                       sel_mode      ? {13'h0000, mode} : 16'h0000;

    // Read data is captured in the setup cycle and held through the access cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup_phase && !pwrite) begin
            prdata <= {16'h0000, read_word};
        end
    end

    // Host-writable control: enable mask and mode select.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_enable_two <= status_irq_pkg::RST_ENABLE;
            mode             <= status_irq_pkg::RST_MODE;
        end else if (wr) begin
            if (sel_enable) event_enable_two <= pwdata[15:0] & status_irq_pkg::ENABLE_MASK;  // [R1]
            if (sel_mode) mode <= pwdata[2:0];
        end
    end

    // Sticky event bits; the enable never stops a bit from being recorded.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            event_status_two <= status_irq_pkg::RST_STATUS;
        end else if (ce) begin
            event_status_two <= {1'b0, sticky[14:6], next_code, sticky[1], 1'b0};  // [R1] [R8] [R9]
        end
    end

    // Interrupt output registered from the pending summary, one cycle behind it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            interrupt_request <= 1'b0;
        end else if (ce) begin
            interrupt_request <= pending;  // [R23]
        end
    end

    // Queue pointer: a host write wins over an advance in the same cycle.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            queue_pointer <= status_irq_pkg::RST_QPTR;
        end else if (wr && sel_qptr) begin
            queue_pointer <= pwdata[15:0];  // [R12]
        end else if (ce && queue_advance) begin
            queue_pointer <= {queue_pointer[15:6], next_qptr_low};  // [R12]
        end
    end

    // Self-test flags are sampled in every cycle with ce high; unused bits are held at zero.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            self_test_status <= 16'h0000;
        end else if (ce) begin
            self_test_status <= {self_test.proto_complete, self_test.proto_running,
                                 self_test.proto_passed, self_test.proto_abort,
                                 self_test.proto_complete | self_test.proto_running,  // [R13]
                                 3'h0, self_test.ram_complete, self_test.ram_running,
                                 self_test.ram_passed, 5'h00};  // [R14]
        end
    end

    // Block status word fields composed at message end.
    wire logic unexpected_status_seen = msg.rt_status != msg.expected_status;  // [R19]
    wire logic masked_status_seen     = |(msg.status_mask & msg.mask_hits);  // [R21]
    wire logic last_echo_bad          = msg.tx_last_word != msg.echo_last_word;
    wire logic echo_fail_final        = echo_check_fail | msg.word_invalid | last_echo_bad;  // [R20]
    wire logic error_summary          = msg.format_error | msg.response_timeout |
                                        echo_fail_final | msg.handshake_fail;  // [R18]
    wire logic [1:0] retry_code = (msg.retries == 2'h0) ? status_irq_pkg::RETRY_NONE :
                                  (msg.retries == 2'h1) ? status_irq_pkg::RETRY_ONE :
                                  status_irq_pkg::RETRY_TWO;  // [R22]
    wire logic [15:0] end_word  = {1'b1, 1'b0, msg.bus_select_flag, error_summary,
                                   unexpected_status_seen, msg.format_error, msg.response_timeout,
                                   echo_fail_final, masked_status_seen, retry_code, 5'h00};  // [R16]
    wire logic [15:0] start_word = {1'b0, 1'b1, msg.bus_select_flag, 13'h0000};  // [R16] [R17]
    wire logic msg_starts = ce && msg_state == status_irq_pkg::MSG_IDLE && msg.message_begin;
    wire logic msg_ends   = ce && msg_state == status_irq_pkg::MSG_RUN && msg.message_end;

    // Message tracker: start and end each push the word out to shared RAM.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            msg_state       <= status_irq_pkg::MSG_IDLE;
            echo_check_fail <= 1'b0;
        end else if (ce) begin
            case (msg_state)
                status_irq_pkg::MSG_IDLE: begin
                    echo_check_fail <= 1'b0;
                    if (msg.message_begin) msg_state <= status_irq_pkg::MSG_RUN;
                end
                status_irq_pkg::MSG_RUN: begin
                    echo_check_fail <= echo_check_fail | msg.word_invalid;  // [R20]
                    if (msg.message_end) msg_state <= status_irq_pkg::MSG_IDLE;
                end
                default: msg_state <= status_irq_pkg::MSG_IDLE;
            endcase
        end
    end

    // Host copy of the word and the RAM write strobe; hardware updates win over host writes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            controller_message_status <= status_irq_pkg::RST_MSG_STAT;
            bsw_write                 <= '0;
        end else if (ce) begin
            bsw_write.valid <= msg_starts | msg_ends;  // [R15]
            if (msg_ends) begin
                controller_message_status <= end_word;  // [R16]
                bsw_write.data            <= end_word;  // [R15]
            end else if (msg_starts) begin
                controller_message_status <= start_word;
                bsw_write.data            <= start_word;
            end else if (wr && sel_msg) begin
                controller_message_status <= pwdata[15:0];  // [R15]
            end
        end
    end

    // Checks on the block's own outputs and state.
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    chk_event_sticky_set: assert property (ce && events.instruction_parity_fault |=>  // [R2]
        event_status_two[status_irq_pkg::BIT_PARITY]) else $error("parity event not recorded");
    chk_irq_masked: assert property (ce && !pending |=> !interrupt_request)  // [R1]
        else $error("interrupt raised with no enabled event");
    chk_irq_follows: assert property (ce && pending |=> interrupt_request)  // [R23]
        else $error("interrupt missed an enabled pending event");
    chk_illegal_cmd: assert property (ce && rt_mode && events.illegal_command_event |=>  // [R3]
        event_status_two[status_irq_pkg::BIT_ILLEGAL]) else $error("illegal command not flagged");
    chk_stack_mode: assert property (ce && ebc_mode && events.call_stack_fault |=>  // [R5]
        event_status_two[status_irq_pkg::BIT_STACK]) else $error("stack fault not flagged");
    chk_request_code: assert property (ce && events.request_strobe |=>  // [R8]
        event_status_two[5:2] == $past(events.controller_request_code)) else $error("request code wrong");
    chk_queue_wrap: assert property (ce && queue_wrap_event && !(wr && sel_qptr) |=>  // [R4]
        event_status_two[status_irq_pkg::BIT_QWRAP] && queue_pointer[5:0] == 6'h00)
        else $error("queue wrap not handled");
    chk_summary_bit: assert property (setup_phase && !pwrite && sel_status |=>  // [R11]
        prdata[0] == $past(events.first_status_summary)) else $error("summary bit wrong");
    chk_self_test_zero: assert property (self_test_status[10:8] == 3'h0 &&  // [R14]
        self_test_status[4:0] == 5'h00) else $error("self-test reserved bits set");
    chk_message_end: assert property (msg_ends |=> bsw_write.valid && bsw_write.data[15] &&  // [R16]
        !bsw_write.data[14] && bsw_write.data[13] == $past(msg.bus_select_flag))
        else $error("end word wrong");
    chk_retry_two: assert property (msg_ends && msg.retries == 2'h3 |=>  // [R22]
        bsw_write.data[6:5] == 2'h2) else $error("retry encoding wrong");
    chk_handshake_only: assert property (msg_ends && msg.handshake_fail && !msg.format_error &&  // [R18]
        !msg.response_timeout && !echo_fail_final |=> bsw_write.data[12] && bsw_write.data[10:8] == 3'h0)
        else $error("handshake failure not flagged");

    cov_irq_raised: cover property (ce && events.self_test_done ##1 pending ##1 interrupt_request);
    cov_read_clear: cover property (rd_status && prdata[status_irq_pkg::BIT_PARITY]);
    cov_message_done: cover property (msg_starts ##[1:20] msg_ends);
    cov_queue_wrap: cover property (ce && queue_wrap_event);

endmodule : status_interrupt_reporting

`default_nettype wire

//--- apb_host_model.sv
// Host processor model: an APB master that issues one transfer per call.
// Assumes pready is sampled only at rising edges of pclk.
`timescale 1ns/10ps
`default_nettype none
module apb_host_model (
    input  wire logic        pclk,
    input  wire logic        pready,
    input  wire logic        pslverr,
    input  wire logic [31:0] prdata,
    output var  logic        psel,
    output var  logic        penable,
    output var  logic        pwrite,
    output var  logic [11:0] paddr,
    output var  logic [31:0] pwdata
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;

    // One idle edge precedes each setup, so back-to-back calls never drive psel twice in a step.
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : apb_host_model
`default_nettype wire

//--- status_interrupt_reporting_tb_top.sv
// Self-checking bench: a register model in 16-bit vectors is compared with every read and with the irq, queue pointer and block word outputs.
// Assumes apb_host_model drives the register bus; ce stays high throughout.
`timescale 1ns/10ps
`default_nettype none
module status_interrupt_reporting_tb_top;
    logic pclk = 0, presetn = 0, ce = 1, queue_advance = 0, pready, pslverr, interrupt_request, e;
    logic psel, penable, pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic [15:0] queue_pointer, m_stat = 0, m_en = 0, q;
    status_irq_pkg::event_in_s  events = '0;
    status_irq_pkg::self_test_s self_test = '0, s;
    status_irq_pkg::msg_in_s    msg = '0, m;
    status_irq_pkg::bsw_write_s bsw_write;
    int n_errors = 0, samples_checked = 0, seed = 74907, cycles = 0;
    int eb[10] = '{15, 14, 13, 12, 11, 10, 9, 8, 7, 1};
    int sb[10] = '{14, 13, 13, 11, 10, 9, 8, 7, 6, 1};

    always #5 pclk = ~pclk;

    status_interrupt_reporting DUT (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .events, .self_test, .msg, .queue_advance, .queue_pointer,
        .bsw_write, .interrupt_request);
    apb_host_model host (.pclk, .pready, .pslverr, .prdata, .psel, .penable, .pwrite, .paddr, .pwdata);

    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results

    // A hang is counted as a mismatch and closes the run.
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            results();
        end
    end

    task automatic check(string nm, logic [31:0] seen, logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check

    task automatic rd(logic [11:0] a, logic [31:0] exp, logic ee = 0);
        host.xfer(1'b0, a, 32'h0, r, e);
        check("prdata", r, exp);
        check("pslverr", {31'h0, e}, {31'h0, ee});
    endtask : rd

    task automatic wr(logic [11:0] a, logic [31:0] d, logic ee = 0);
        host.xfer(1'b1, a, d, r, e);
        check("pslverr", {31'h0, e}, {31'h0, ee});
    endtask : wr

    // The status read returns the model and then clears the event bits it returned.
    task automatic rd_stat(logic s0);
        rd(status_irq_pkg::ADDR_STATUS, {16'h0, |(m_stat[14:1] & m_en[14:1]), m_stat[14:1], s0});
        m_stat = 0;
    endtask : rd_stat

    // Pulse driven at the first edge and sampled at the second; the interrupt output settles after the third.
    task automatic pulse(logic [15:0] v);
        @(posedge pclk) events <= status_irq_pkg::event_in_s'(v);
        @(posedge pclk) events <= status_irq_pkg::event_in_s'(v & 16'h1);
        @(posedge pclk) #1;
        check("irq", {31'h0, interrupt_request}, {31'h0, |(m_stat[14:1] & m_en[14:1])});
    endtask : pulse

    task automatic run_msg(logic bus, logic [1:0] rt, logic err, logic [15:0] exp, logic hs = 0);
        m = '0;
        m.message_begin = 1;
        m.bus_select_flag = bus;
        @(posedge pclk) msg <= m;
        m.message_begin = 0;
        @(posedge pclk) msg <= m;
        #1 check("bsw start", 32'({bsw_write.valid, bsw_write.data}), {15'h0, 3'h5, bus, 13'h0});
        {m.message_end, m.retries, m.format_error, m.rt_status[0], m.status_mask[0]} = {1'b1, rt, {3{err}}};
        m.mask_hits = 6'h1;
        m.handshake_fail = hs;
        m.echo_last_word = {15'h0, ~(err | hs)};
        @(posedge pclk) msg <= m;
        m.message_end = 0;
        @(posedge pclk) msg <= m;
        #1 check("bsw end", 32'({bsw_write.valid, bsw_write.data}), {15'h1, exp});
        rd(status_irq_pkg::ADDR_MSG_STAT, {16'h0, exp});
    endtask : run_msg

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1;
        rd(status_irq_pkg::ADDR_ENABLE, 0);
        rd(status_irq_pkg::ADDR_QPTR, 0);
        rd_stat(0);
        self_test <= status_irq_pkg::self_test_s'(7'($random(seed)));
        @(posedge pclk) s = self_test;
        rd(status_irq_pkg::ADDR_SELF_TEST, {s[6:3], s[6] | s[5], 3'h0, s[2:0], 5'h0});
        wr(status_irq_pkg::ADDR_STATUS, 32'hffff, 1);
        rd(12'hffc, 0, 1);
        $display("test reset and access done");
        m_en = 16'($random(seed)) & status_irq_pkg::ENABLE_MASK;
        wr(status_irq_pkg::ADDR_ENABLE, {16'h0, m_en});
        rd(status_irq_pkg::ADDR_ENABLE, {16'h0, m_en});
        wr(status_irq_pkg::ADDR_MODE, 32'h7);
        for (int i = 0; i < 10; i++) begin
            m_stat[sb[i]] = 1;
            pulse(16'h1 << eb[i]);
            rd_stat(0);
        end
        q = 16'($random(seed)) & 16'h3c;
        m_stat[5:2] = q[5:2];
        pulse({9'h0, 1'b1, q[5:2], 2'h0});
        @(posedge pclk) events <= status_irq_pkg::event_in_s'(16'h1);
        rd_stat(1);
        wr(status_irq_pkg::ADDR_MODE, 32'h0);
        pulse(16'h1001);
        rd_stat(1);
        $display("test events done");
        wr(status_irq_pkg::ADDR_MODE, 32'h2);
        q = 16'($random(seed)) | 16'h3f;
        wr(status_irq_pkg::ADDR_QPTR, {16'h0, q});
        @(posedge pclk) queue_advance <= 1;
        @(posedge pclk) queue_advance <= 0;
        @(posedge pclk) #1 check("qptr", {16'h0, queue_pointer}, {16'h0, q[15:6], 6'h0});
        m_stat[12] = 1;
        rd_stat(1);
        run_msg(1, 3, 1, 16'hbcc0);
        run_msg(0, 1, 0, 16'h9120);
        run_msg(0, 2, 0, 16'h9040, 1);
        wr(status_irq_pkg::ADDR_MSG_STAT, 32'h5);
        rd(status_irq_pkg::ADDR_MSG_STAT, 32'h5);
        $display("test queue and message done");
        results();
    end
endmodule : status_interrupt_reporting_tb_top
`default_nettype wire
